// ==== pkg/pcc_pkg.sv ====
// constants, field positions and carriers for the port command and identity block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package pcc_pkg;

    // configuration space byte offsets
    localparam logic [11:0] PCC_OFS_IDENT   = 12'h000;
    localparam logic [11:0] PCC_OFS_COMMAND = 12'h004;

    // command register field positions
    localparam int PCC_CMD_IO    = 0;
    localparam int PCC_CMD_MEM   = 1;
    localparam int PCC_CMD_MAST  = 2;
    localparam int PCC_CMD_PERR  = 6;
    localparam int PCC_CMD_ERREP = 8;
    localparam int PCC_CMD_INTD  = 10;

    // status flag positions in the upper half of the command word
    localparam int PCC_STS_MDPE = 24;
    localparam int PCC_STS_SSE  = 30;

    // implemented command bits and their reset value
    localparam logic [15:0] PCC_CMD_MASK  = 16'h0547;
    localparam logic [15:0] PCC_CMD_RESET = 16'h0000;

    // identity defaults, arbitrary values
    localparam logic [15:0] PCC_MAKER_DEF = 16'h0a5a;
    localparam logic [15:0] PCC_PART_DEF  = 16'h0c3c;

    // gated event channels
    localparam int PCC_EV_INTX  = 0;
    localparam int PCC_EV_ERR   = 1;
    localparam int PCC_EV_PERR  = 2;
    localparam int PCC_EV_IO    = 3;
    localparam int PCC_EV_MEM   = 4;
    localparam int PCC_EV_COUNT = 5;

    // configuration request from the upstream hierarchy
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] data;
    } pcc_cfg_req_t;

    // preload word from the serial loader
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
    } pcc_load_t;

    // request arriving from the downstream side
    typedef struct packed {
        logic memIo;
        logic nonPosted;
    } pcc_dn_req_t;

endpackage

// ==== hdl/pcc_gate.sv ====
// one registered event gate: passes a pulse only while its enable is set
`timescale 1ns/1ps
module pcc_gate (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic evt,
    input  wire logic en,
    output logic      pulse_r
);
    //--------------------------------------------------------------------------
    // gate
    //--------------------------------------------------------------------------
    // the enable is sampled in the same cycle as the event
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= evt & en;
        end
    end
endmodule // pcc_gate

// ==== hdl/pcc_port_cfg.sv ====
// identity words, command register and the gating it drives
`timescale 1ns/1ps
module pcc_port_cfg
    import pcc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         cfgReq,
    input  pcc_cfg_req_t      cfgIn,
    output logic              cfgAck_r,
    output logic [31:0]       cfgRdData_r,
    input  wire logic         ldValid,
    input  pcc_load_t         ldIn,
    input  wire logic         priIoReq,
    input  wire logic         priMemReq,
    output logic              priIoAccept_r,
    output logic              priMemAccept_r,
    input  wire logic         dnReqValid,
    input  pcc_dn_req_t       dnReq,
    output logic              dnForward_r,
    output logic              dnUrDrop_r,
    output logic              dnUrCpl_r,
    input  wire logic         ownIntxReq,
    input  wire logic         fwdIntxReq,
    output logic              intxSend_r,
    output logic              intxFwd_r,
    input  wire logic         errDetected,
    output logic              errMsgSend_r,
    input  wire logic         parityErr,
    output logic              parityAction_r,
    output logic [15:0]       cmdOut_r,
    output logic              stsMdpe_r,
    output logic              stsSse_r
);
    //--------------------------------------------------------------------------
    // storage
    //--------------------------------------------------------------------------
    logic [15:0] maker_r;
    logic [15:0] part_r;
    logic [15:0] cmd_r;
    logic [15:0] cmd_nxt;
    logic        mdpe_nxt;
    logic        sse_nxt;

    //--------------------------------------------------------------------------
    // decode
    //--------------------------------------------------------------------------
    // configuration decode and byte lanes
    wire         cfgWrite  = cfgReq & cfgIn.wr;
    wire         hitIdent  = cfgIn.addr == PCC_OFS_IDENT;
    wire         hitCmd    = cfgIn.addr == PCC_OFS_COMMAND;
    wire         cmdWrLo   = cfgWrite & hitCmd & cfgIn.be[0];
    wire         cmdWrHi   = cfgWrite & hitCmd & cfgIn.be[1];
    wire         stsWrTop  = cfgWrite & hitCmd & cfgIn.be[3];
    wire         ldIdent   = ldValid & (ldIn.addr == PCC_OFS_IDENT);
    wire         ldCmd     = ldValid & (ldIn.addr == PCC_OFS_COMMAND);

    // command bits as the block uses them
    wire         enIo      = cmd_r[PCC_CMD_IO];
    wire         enMem     = cmd_r[PCC_CMD_MEM];
    wire         enMaster  = cmd_r[PCC_CMD_MAST];
    wire         enPerr    = cmd_r[PCC_CMD_PERR];
    wire         enErrRep  = cmd_r[PCC_CMD_ERREP];
    wire         intDis    = cmd_r[PCC_CMD_INTD];

    // merged command write: software lanes first, loader overrides
    wire [15:0]  swCmd     = {cmdWrHi ? cfgIn.data[15:8] : cmd_r[15:8],
                              cmdWrLo ? cfgIn.data[7:0]  : cmd_r[7:0]};
    wire [15:0]  ldCmdVal  = ldIn.data[15:0];

    // clearing only from software write-one
    wire         clrMdpe   = stsWrTop & cfgIn.data[PCC_STS_MDPE];
    wire         clrSse    = stsWrTop & cfgIn.data[PCC_STS_SSE];

    // read data assembly
    wire [31:0]  rdIdent   = {part_r, maker_r};
    // bit 31 is not kept here and reads zero; the two flags sit at 30 and 24
    wire [31:0]  rdCmd     = {1'b0, stsSse_r, 5'h00, stsMdpe_r, 8'h00,
                              cmd_r & PCC_CMD_MASK};
    wire [31:0]  rdWord    = hitIdent ? rdIdent :
                             hitCmd   ? rdCmd   : 32'h0000_0000;

    // downstream request classification
    wire         dnMemIo   = dnReqValid & dnReq.memIo;

    //--------------------------------------------------------------------------
    // next values
    //--------------------------------------------------------------------------
    // reserved bits never store, so they read as zero
    always_comb begin
        cmd_nxt = (ldCmd ? ldCmdVal : swCmd) & PCC_CMD_MASK;
        // a new event wins over a software clear in the same cycle
        mdpe_nxt = (stsMdpe_r & ~clrMdpe) | (parityErr & enPerr);
        sse_nxt  = (stsSse_r & ~clrSse) | (errDetected & enErrRep);
    end

    //--------------------------------------------------------------------------
    // identity and command registers
    //--------------------------------------------------------------------------
    // identity words take loader data only, never configuration writes
    always_ff @(posedge clk) begin
        if (rst) begin
            maker_r <= PCC_MAKER_DEF;
            part_r  <= PCC_PART_DEF;
        end else if (ldIdent) begin
            maker_r <= ldIn.data[15:0];
            part_r  <= ldIn.data[31:16];
        end
    end

    // command bits and status flags
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_r     <= PCC_CMD_RESET;
            stsMdpe_r <= 1'b0;
            stsSse_r  <= 1'b0;
        end else begin
            cmd_r     <= cmd_nxt;
            stsMdpe_r <= mdpe_nxt;
            stsSse_r  <= sse_nxt;
        end
    end

    // command copy for the rest of the port
    always_ff @(posedge clk) begin
        if (rst) begin
            cmdOut_r <= PCC_CMD_RESET;
        end else begin
            cmdOut_r <= cmd_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // configuration answer
    //--------------------------------------------------------------------------
    // every request is answered one cycle later; writes return zero data
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgAck_r    <= 1'b0;
            cfgRdData_r <= 32'h0000_0000;
        end else begin
            cfgAck_r    <= cfgReq;
            cfgRdData_r <= (cfgReq & ~cfgIn.wr) ? rdWord : 32'h0000_0000;
        end
    end

    //--------------------------------------------------------------------------
    // event gates
    //--------------------------------------------------------------------------
    logic [PCC_EV_COUNT-1:0] evIn;
    logic [PCC_EV_COUNT-1:0] evEn;
    logic [PCC_EV_COUNT-1:0] evOut;

    // pairing of each event with the command bit that gates it
    assign evIn[PCC_EV_INTX] = ownIntxReq;
    assign evEn[PCC_EV_INTX] = ~intDis;
    assign evIn[PCC_EV_ERR]  = errDetected;
    assign evEn[PCC_EV_ERR]  = enErrRep;
    assign evIn[PCC_EV_PERR] = parityErr;
    assign evEn[PCC_EV_PERR] = enPerr;
    assign evIn[PCC_EV_IO]   = priIoReq;
    assign evEn[PCC_EV_IO]   = enIo;
    assign evIn[PCC_EV_MEM]  = priMemReq;
    assign evEn[PCC_EV_MEM]  = enMem;

    genvar g;
    generate
        for (g = 0; g < PCC_EV_COUNT; g++) begin : gEv
            pcc_gate uGate (
                .clk     (clk),
                .rst     (rst),
                .evt     (evIn[g]),
                .en      (evEn[g]),
                .pulse_r (evOut[g])
            );
        end
    endgenerate

    // gated pulses copied to flopped outputs, one more stage
    always_ff @(posedge clk) begin
        if (rst) begin
            intxSend_r     <= 1'b0;
            errMsgSend_r   <= 1'b0;
            parityAction_r <= 1'b0;
            priIoAccept_r  <= 1'b0;
            priMemAccept_r <= 1'b0;
        end else begin
            intxSend_r     <= evOut[PCC_EV_INTX];
            errMsgSend_r   <= evOut[PCC_EV_ERR];
            parityAction_r <= evOut[PCC_EV_PERR];
            priIoAccept_r  <= evOut[PCC_EV_IO];
            priMemAccept_r <= evOut[PCC_EV_MEM];
        end
    end

    //--------------------------------------------------------------------------
    // downstream requests and forwarded interrupts
    //--------------------------------------------------------------------------
    // forwarded interrupt messages ignore the interrupt disable bit
    always_ff @(posedge clk) begin
        if (rst) begin
            intxFwd_r   <= 1'b0;
            dnForward_r <= 1'b0;
            dnUrDrop_r  <= 1'b0;
            dnUrCpl_r   <= 1'b0;
        end else begin
            intxFwd_r   <= fwdIntxReq;
            dnForward_r <= dnMemIo & enMaster;
            dnUrDrop_r  <= dnMemIo & ~enMaster & ~dnReq.nonPosted;
            dnUrCpl_r   <= dnMemIo & ~enMaster & dnReq.nonPosted;
        end
    end
endmodule // pcc_port_cfg

// ==== test/pcc_port_cfg_assertions.sv ====
// concurrent checks on the port command and identity block
`timescale 1ns/1ps
module pcc_port_cfg_assertions
    import pcc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cfgReq,
    input  wire logic        cfgAck_r,
    input  wire logic        priIoReq,
    input  wire logic        priIoAccept_r,
    input  wire logic        priMemReq,
    input  wire logic        priMemAccept_r,
    input  wire logic        dnReqValid,
    input  pcc_dn_req_t      dnReq,
    input  wire logic        dnForward_r,
    input  wire logic        dnUrCpl_r,
    input  wire logic        ownIntxReq,
    input  wire logic        intxSend_r,
    input  wire logic        errDetected,
    input  wire logic        errMsgSend_r,
    input  wire logic        parityErr,
    input  wire logic        parityAction_r,
    input  wire logic [15:0] cmdOut_r,
    input  wire logic        stsMdpe_r,
    input  wire logic        stsSse_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // primary accesses taken with their enable set
    sequence s_io;  priIoReq && cmdOut_r[PCC_CMD_IO];   endsequence
    sequence s_mem; priMemReq && cmdOut_r[PCC_CMD_MEM]; endsequence
    AST_IO_GATE: assert property (s_io |-> ##2 priIoAccept_r)
        else $error("io access not accepted");
    AST_MEM_GATE: assert property (s_mem |-> ##2 priMemAccept_r)
        else $error("memory access not accepted");
    AST_MEM_BLOCK: assert property (priMemReq && !cmdOut_r[PCC_CMD_MEM] |-> ##2 !priMemAccept_r)
        else $error("memory access accepted while disabled");
    AST_UR_CPL: assert property (dnReqValid && dnReq.memIo && dnReq.nonPosted
        && !cmdOut_r[PCC_CMD_MAST] |=> dnUrCpl_r && !dnForward_r)
        else $error("unsupported completion missing");
    AST_FWD: assert property (dnForward_r |-> $past(dnReqValid && cmdOut_r[PCC_CMD_MAST]))
        else $error("forward without master enable");
    AST_INTX: assert property (ownIntxReq |-> ##2 intxSend_r == !$past(cmdOut_r[PCC_CMD_INTD], 2))
        else $error("own interrupt gating wrong");
    AST_ERR: assert property (errDetected |-> ##2 errMsgSend_r == $past(cmdOut_r[PCC_CMD_ERREP], 2))
        else $error("error report gating wrong");
    AST_PAR: assert property (parityErr |-> ##2 parityAction_r == $past(cmdOut_r[PCC_CMD_PERR], 2))
        else $error("parity action gating wrong");
    AST_RSV: assert property ((cmdOut_r & ~PCC_CMD_MASK) == 16'h0000)
        else $error("reserved command bit set");
    AST_SSE: assert property ($rose(stsSse_r) |-> $past(errDetected && cmdOut_r[PCC_CMD_ERREP]))
        else $error("system error flag set while disabled");
    AST_MDPE: assert property ($rose(stsMdpe_r) |-> $past(parityErr && cmdOut_r[PCC_CMD_PERR]))
        else $error("parity flag set while disabled");
    AST_ACK: assert property (cfgReq |=> cfgAck_r)
        else $error("configuration request not acknowledged");
endmodule // pcc_port_cfg_assertions
bind pcc_port_cfg pcc_port_cfg_assertions i_chk (.*);

// ==== test/pcc_root_model.sv ====
// upstream hierarchy model issuing configuration accesses
`timescale 1ns/1ps
module pcc_root_model
    import pcc_pkg::*;
(
    input  wire logic        clk,
    output logic             cfgReq,
    output pcc_cfg_req_t     cfgIn,
    input  wire logic        cfgAck_r,
    input  wire logic [31:0] cfgRdData_r
);
    // idle bus at time zero
    initial begin
        cfgReq = 1'b0;
        cfgIn  = '0;
    end
    // one request cycle, answer taken at the next edge
    task automatic access(input logic wr, input logic [11:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #1;
        cfgReq = 1'b1;
        cfgIn  = '{wr, a, be, d};
        @(posedge clk);
        #1;
        cfgReq = 1'b0;
        cfgIn  = '{~wr, ~a, ~be, ~d};  // released bus keeps no stale value
        q = (cfgAck_r === 1'b1) ? cfgRdData_r : 'x;
    endtask
endmodule // pcc_root_model

// ==== test/tb_pcc_port_cfg.sv ====
// self-checking bench for the port command and identity block
`timescale 1ns/1ps
module tb_pcc_port_cfg;
    import pcc_pkg::*;
    localparam int NLOOP = 40;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         cfgReq, cfgAck_r, ldValid, priIoReq, priMemReq, priIoAccept_r;
    logic         priMemAccept_r, dnReqValid, dnForward_r, dnUrDrop_r, dnUrCpl_r;
    logic         ownIntxReq, fwdIntxReq, intxSend_r, intxFwd_r, errDetected;
    logic         errMsgSend_r, parityErr, parityAction_r, stsMdpe_r, stsSse_r;
    logic [31:0]  cfgRdData_r, rd, r;
    logic [31:0]  seed = 32'h0000_0021;
    logic [15:0]  cmdOut_r, c;
    pcc_cfg_req_t cfgIn;
    pcc_load_t    ldIn;
    pcc_dn_req_t  dnReq;
    int           error_cnt = 0;
    int           n_tests = 0;

    always #2 clk = ~clk;
    pcc_port_cfg i_dut (.*);
    pcc_root_model i_rc (.clk(clk), .cfgReq(cfgReq), .cfgIn(cfgIn), .cfgAck_r(cfgAck_r),
                         .cfgRdData_r(cfgRdData_r));

    // xorshift source
    function automatic logic [31:0] xrnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected word at the command offset
    function automatic logic [31:0] expCmd(input logic [15:0] v, input logic s, input logic m);
        return {1'b0, s, 5'h00, m, 8'h00, v & PCC_CMD_MASK};
    endfunction
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic test_done();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // every event at once, outputs checked at their latencies
    task automatic fire(input logic [15:0] v, input logic mi, input logic np);
        cmp("cmdOut", {16'h0000, v & PCC_CMD_MASK}, {16'h0000, cmdOut_r});
        {priIoReq, priMemReq, ownIntxReq, fwdIntxReq, errDetected, parityErr} = 6'h3f;
        dnReqValid = 1'b1;
        dnReq = '{mi, np};
        tick();
        {priIoReq, priMemReq, ownIntxReq, fwdIntxReq, errDetected, parityErr} = 6'h00;
        dnReqValid = 1'b0;
        cmp("intxFwd", 32'(1'b1), 32'(intxFwd_r));
        cmp("dnFwd", 32'(mi & v[2]), 32'(dnForward_r));
        cmp("urCpl", 32'(mi & ~v[2] & np), 32'(dnUrCpl_r));
        cmp("urDrop", 32'(mi & ~v[2] & ~np), 32'(dnUrDrop_r));
        tick();
        cmp("ioAcc", 32'(v[0]), 32'(priIoAccept_r));
        cmp("memAcc", 32'(v[1]), 32'(priMemAccept_r));
        cmp("intxSend", {31'h0, ~v[10]}, {31'h0, intxSend_r});
        cmp("errMsg", 32'(v[8]), 32'(errMsgSend_r));
        cmp("parAct", 32'(v[6]), 32'(parityAction_r));
        cmp("flags", {30'h0, v[8], v[6]}, {30'h0, stsSse_r, stsMdpe_r});
    endtask

    // watchdog
    initial begin
        #(NLOOP * 400 * 4);
        error_cnt++;
        test_done();
    end
    // main sequence
    initial begin
        {ldValid, priIoReq, priMemReq, dnReqValid, ownIntxReq, fwdIntxReq} = 6'h00;
        {errDetected, parityErr} = 2'h0;
        ldIn = '0;
        dnReq = '0;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        i_rc.access(1'b0, PCC_OFS_COMMAND, 4'hf, 32'h0, rd);
        cmp("cmdRst", 32'h0, rd);
        i_rc.access(1'b1, PCC_OFS_IDENT, 4'hf, 32'hffff_ffff, rd);
        i_rc.access(1'b0, PCC_OFS_IDENT, 4'hf, 32'h0, rd);
        cmp("ids", {PCC_PART_DEF, PCC_MAKER_DEF}, rd);
        i_rc.access(1'b1, PCC_OFS_COMMAND, 4'h3, 32'h0000_ffff, rd);
        i_rc.access(1'b0, PCC_OFS_COMMAND, 4'hf, 32'h0, rd);
        cmp("cmdAll", 32'(PCC_CMD_MASK), rd);
        i_rc.access(1'b0, 12'h008, 4'hf, 32'h0, rd);
        cmp("unmapped", 32'h0, rd);
        r = xrnd();
        ldIn = '{PCC_OFS_IDENT, r};
        ldValid = 1'b1;
        tick();
        ldValid = 1'b0;
        i_rc.access(1'b0, PCC_OFS_IDENT, 4'hf, 32'h0, rd);
        cmp("idsLoad", r, rd);
        for (int i = 0; i < NLOOP; i++) begin
            r = xrnd();
            c = r[15:0];
            if (r[20]) begin
                ldIn = '{PCC_OFS_COMMAND, {16'h0000, c}};
                ldValid = 1'b1;
                tick();
                ldValid = 1'b0;
                i_rc.access(1'b1, PCC_OFS_COMMAND, 4'h8, 32'h4100_0000, rd);
            end else begin
                i_rc.access(1'b1, PCC_OFS_COMMAND, 4'hb, {8'h41, 8'h00, c}, rd);
            end
            fire(c, r[21], r[22]);
            i_rc.access(1'b0, PCC_OFS_COMMAND, 4'hf, 32'h0, rd);
            cmp("cmdSts", expCmd(c, c[8], c[6]), rd);
        end
        rst = 1'b1;
        tick();
        tick();
        rst = 1'b0;
        i_rc.access(1'b0, PCC_OFS_COMMAND, 4'hf, 32'h0, rd);
        cmp("cmdReRst", 32'h0, rd);
        i_rc.access(1'b0, PCC_OFS_IDENT, 4'hf, 32'h0, rd);
        cmp("idsReRst", {PCC_PART_DEF, PCC_MAKER_DEF}, rd);
        test_done();
    end
endmodule // tb_pcc_port_cfg
